// ---- pkg/pcd_regs.vh ----
/*
 * pcd_regs.vh: pin positions, reset values and timing counts for the
 * port c / port d alternate-function override block.
 * assumes it is included by bare name from the design files only.
 */
`ifndef PCD_REGS_VH
`define PCD_REGS_VH

// port c pin positions
`define PCD_PC_SCL 0
`define PCD_PC_SDA 1
`define PCD_PC_TCK 2
`define PCD_PC_TMS 3
`define PCD_PC_TDO 4
`define PCD_PC_TDI 5

// port d pin positions
`define PCD_PD_RXD 0
`define PCD_PD_TXD 1
`define PCD_PD_IRQ0 2
`define PCD_PD_IRQ1 3
`define PCD_PD_CMP1B 4
`define PCD_PD_CMP1A 5
`define PCD_PD_CAPT 6
`define PCD_PD_CMP2 7

// reset values of every registered pin-side output
`define PCD_RST_BYTE 8'h00

// timing: clock period and spike filter width, both in ns
`define PCD_CLK_PERIOD_NS 100
`define PCD_SPIKE_NS 50
// least time, rounded up to whole cycles, one or more for any nonzero width
`define PCD_SPIKE_CYC ((`PCD_SPIKE_NS + `PCD_CLK_PERIOD_NS - 1) / \
    `PCD_CLK_PERIOD_NS)

`endif

// ---- hdl/pcd_spike_filter.v ----
/*
 * pcd_spike_filter: passes a level only after it has held steady for
 * STABLE_CYCLES clocks, so shorter pulses never reach the output.
 * assumes its input is already synchronised to clk_in.
 */
`timescale 1ns/1ps
module pcd_spike_filter #(
    parameter STABLE_CYCLES = 1,
    parameter CNT_W = 4
)
(
    input wire clk_in,
    input wire reset_in,
    input wire level_in,
    output reg level_out
);

reg [CNT_W-1:0] stable_cnt_reg;

// count cycles the input differs from the output; take it once long enough
always @(posedge clk_in)
begin
    if (reset_in)
    begin
        stable_cnt_reg <= {CNT_W{1'b0}};
        level_out <= 1'b1;   // bus lines idle high
    end
    else if (level_in == level_out)
    begin
        stable_cnt_reg <= {CNT_W{1'b0}};
    end
    else if (stable_cnt_reg >= STABLE_CYCLES[CNT_W-1:0] - 1'b1)
    begin
        stable_cnt_reg <= {CNT_W{1'b0}};
        level_out <= level_in;
    end
    else
    begin
        stable_cnt_reg <= stable_cnt_reg + 1'b1;
    end
end

endmodule // pcd_spike_filter

// ---- hdl/pcd_pin_override.v ----
/*
 * pcd_pin_override: alternate-function override logic for ports c and d.
 * merges port register values with the pull-up, direction, output value
 * and input enable overrides of test port, two-wire, timer, interrupt and
 * serial functions, and routes pin inputs back to those functions.
 * assumes port registers and peripheral signals come from logic on clk_in
 * and pin inputs arrive asynchronously from the pads.
 */
`timescale 1ns/1ps
`include "pcd_regs.vh"

module pcd_pin_override #(
    parameter SPIKE_CYCLES = `PCD_SPIKE_CYC
)
(
    input wire clk_in,
    input wire reset_in,
    input wire global_pullup_disable_in,
    input wire [7:0] portc_value_in,
    input wire [7:0] portc_direction_in,
    input wire [7:0] portd_value_in,
    input wire [7:0] portd_direction_in,
    input wire [7:0] portc_pad_in,
    input wire [7:0] portd_pad_in,
    input wire test_iface_enable_in,
    input wire instr_shift_state_in,
    input wire data_shift_state_in,
    input wire test_shift_data_in,
    input wire two_wire_enable_in,
    input wire two_wire_sda_drive_in,
    input wire two_wire_scl_drive_in,
    input wire timer2_compare_enable_in,
    input wire timer2_compare_in,
    input wire timer1_compare_a_enable_in,
    input wire timer1_compare_a_in,
    input wire timer1_compare_b_enable_in,
    input wire timer1_compare_b_in,
    input wire ext_irq_zero_enable_in,
    input wire ext_irq_one_enable_in,
    input wire serial_tx_enable_in,
    input wire serial_tx_data_in,
    input wire serial_rx_enable_in,
    output reg [7:0] portc_pad_out,
    output reg [7:0] portc_pad_oe_out,
    output reg [7:0] portc_pullup_out,
    output reg [7:0] portc_input_en_out,
    output reg [7:0] portd_pad_out,
    output reg [7:0] portd_pad_oe_out,
    output reg [7:0] portd_pullup_out,
    output reg [7:0] portd_input_en_out,
    output reg [7:0] portc_pin_value_out,
    output reg [7:0] portd_pin_value_out,
    output reg test_data_in_out,
    output reg test_mode_select_out,
    output reg test_clock_out,
    output reg two_wire_sda_out,
    output reg two_wire_scl_out,
    output reg timer1_capture_out,
    output reg ext_irq_zero_out,
    output reg ext_irq_one_out,
    output reg serial_rx_data_out
);

// picks the override value when its enable is set, else the port value
function pick;
    input ovr_en;
    input ovr_val;
    input port_val;
    begin
        pick = ovr_en ? ovr_val : port_val;
    end
endfunction

// override vectors, one bit per pin
reg [7:0] pc_pu_oe, pc_pu_ov, pc_dd_oe, pc_dd_ov;
reg [7:0] pc_pv_oe, pc_pv_ov, pc_die_oe, pc_die_ov;
reg [7:0] pd_pu_oe, pd_pu_ov, pd_dd_oe, pd_dd_ov;
reg [7:0] pd_pv_oe, pd_pv_ov, pd_die_oe, pd_die_ov;

// merged per-pin controls
wire [7:0] pc_pullup_next;
wire [7:0] pc_dir_next;
wire [7:0] pc_val_next;
wire [7:0] pc_die_next;
wire [7:0] pd_pullup_next;
wire [7:0] pd_dir_next;
wire [7:0] pd_val_next;
wire [7:0] pd_die_next;

// pad synchronisers: stage one is read only by stage two
reg [7:0] pc_sync1_reg;
reg [7:0] pc_sync2_reg;
reg [7:0] pd_sync1_reg;
reg [7:0] pd_sync2_reg;

wire sda_filt;
wire scl_filt;
wire test_shifting;

assign test_shifting = instr_shift_state_in | data_shift_state_in;

// port c override table; bits 7:6 carry no function here
always @*
begin
    pc_pu_oe = 8'h00;
    pc_pu_ov = 8'h00;
    pc_dd_oe = 8'h00;
    pc_dd_ov = 8'h00;
    pc_pv_oe = 8'h00;
    pc_pv_ov = 8'h00;
    pc_die_oe = 8'h00;
    pc_die_ov = 8'h00;
    // test data input: pull-up on, input, port input off
    pc_pu_oe[`PCD_PC_TDI] = test_iface_enable_in;
    pc_pu_ov[`PCD_PC_TDI] = 1'b1;
    pc_dd_oe[`PCD_PC_TDI] = test_iface_enable_in;
    pc_die_oe[`PCD_PC_TDI] = test_iface_enable_in;
    // test data output: floats outside the shift states
    pc_pu_oe[`PCD_PC_TDO] = test_iface_enable_in;
    pc_dd_oe[`PCD_PC_TDO] = test_iface_enable_in;
    pc_dd_ov[`PCD_PC_TDO] = test_shifting;
    pc_pv_oe[`PCD_PC_TDO] = test_iface_enable_in;
    pc_pv_ov[`PCD_PC_TDO] = test_shift_data_in;
    pc_die_oe[`PCD_PC_TDO] = test_iface_enable_in;
    // test mode select
    pc_pu_oe[`PCD_PC_TMS] = test_iface_enable_in;
    pc_pu_ov[`PCD_PC_TMS] = 1'b1;
    pc_dd_oe[`PCD_PC_TMS] = test_iface_enable_in;
    pc_die_oe[`PCD_PC_TMS] = test_iface_enable_in;
    // test clock
    pc_pu_oe[`PCD_PC_TCK] = test_iface_enable_in;
    pc_pu_ov[`PCD_PC_TCK] = 1'b1;
    pc_dd_oe[`PCD_PC_TCK] = test_iface_enable_in;
    pc_die_oe[`PCD_PC_TCK] = test_iface_enable_in;
    // two-wire data: open drain, the drive request turns the pin on low
    pc_pu_oe[`PCD_PC_SDA] = two_wire_enable_in;
    pc_pu_ov[`PCD_PC_SDA] = portc_value_in[`PCD_PC_SDA];
    pc_dd_oe[`PCD_PC_SDA] = two_wire_enable_in;
    pc_dd_ov[`PCD_PC_SDA] = two_wire_sda_drive_in;
    pc_pv_oe[`PCD_PC_SDA] = two_wire_enable_in;
    // two-wire clock: same open-drain scheme
    pc_pu_oe[`PCD_PC_SCL] = two_wire_enable_in;
    pc_pu_ov[`PCD_PC_SCL] = portc_value_in[`PCD_PC_SCL];
    pc_dd_oe[`PCD_PC_SCL] = two_wire_enable_in;
    pc_dd_ov[`PCD_PC_SCL] = two_wire_scl_drive_in;
    pc_pv_oe[`PCD_PC_SCL] = two_wire_enable_in;
end

// port d override table; bit 6 has none, capture reads the plain input
always @*
begin
    pd_pu_oe = 8'h00;
    pd_pu_ov = 8'h00;
    pd_dd_oe = 8'h00;
    pd_dd_ov = 8'h00;
    pd_pv_oe = 8'h00;
    pd_pv_ov = 8'h00;
    pd_die_oe = 8'h00;
    pd_die_ov = 8'h00;
    // compare outputs replace the value only; software owns direction
    pd_pv_oe[`PCD_PD_CMP2] = timer2_compare_enable_in;
    pd_pv_ov[`PCD_PD_CMP2] = timer2_compare_in;
    pd_pv_oe[`PCD_PD_CMP1A] = timer1_compare_a_enable_in;
    pd_pv_ov[`PCD_PD_CMP1A] = timer1_compare_a_in;
    pd_pv_oe[`PCD_PD_CMP1B] = timer1_compare_b_enable_in;
    pd_pv_ov[`PCD_PD_CMP1B] = timer1_compare_b_in;
    // interrupt pins keep their input path alive
    pd_die_oe[`PCD_PD_IRQ1] = ext_irq_one_enable_in;
    pd_die_ov[`PCD_PD_IRQ1] = 1'b1;
    pd_die_oe[`PCD_PD_IRQ0] = ext_irq_zero_enable_in;
    pd_die_ov[`PCD_PD_IRQ0] = 1'b1;
    // transmit: forced output, pull-up off
    pd_pu_oe[`PCD_PD_TXD] = serial_tx_enable_in;
    pd_dd_oe[`PCD_PD_TXD] = serial_tx_enable_in;
    pd_dd_ov[`PCD_PD_TXD] = 1'b1;
    pd_pv_oe[`PCD_PD_TXD] = serial_tx_enable_in;
    pd_pv_ov[`PCD_PD_TXD] = serial_tx_data_in;
    // receive: forced input, pull-up still from the port bit
    pd_pu_oe[`PCD_PD_RXD] = serial_rx_enable_in;
    pd_pu_ov[`PCD_PD_RXD] = portd_value_in[`PCD_PD_RXD];
    pd_dd_oe[`PCD_PD_RXD] = serial_rx_enable_in;
end

// per-pin merge; a normal pull-up needs value one on an input pin
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
        assign pc_pullup_next[gi] = ~global_pullup_disable_in &
            pick(pc_pu_oe[gi], pc_pu_ov[gi],
                 portc_value_in[gi] & ~portc_direction_in[gi]);
        assign pc_dir_next[gi] = pick(pc_dd_oe[gi], pc_dd_ov[gi],
            portc_direction_in[gi]);
        assign pc_val_next[gi] = pick(pc_pv_oe[gi], pc_pv_ov[gi],
            portc_value_in[gi]);
        assign pc_die_next[gi] = pick(pc_die_oe[gi], pc_die_ov[gi], 1'b1);
        assign pd_pullup_next[gi] = ~global_pullup_disable_in &
            pick(pd_pu_oe[gi], pd_pu_ov[gi],
                 portd_value_in[gi] & ~portd_direction_in[gi]);
        assign pd_dir_next[gi] = pick(pd_dd_oe[gi], pd_dd_ov[gi],
            portd_direction_in[gi]);
        assign pd_val_next[gi] = pick(pd_pv_oe[gi], pd_pv_ov[gi],
            portd_value_in[gi]);
        assign pd_die_next[gi] = pick(pd_die_oe[gi], pd_die_ov[gi], 1'b1);
    end
endgenerate

// two flops on every pad input before any logic sees it
always @(posedge clk_in)
begin
    if (reset_in)
    begin
        pc_sync1_reg <= `PCD_RST_BYTE;
        pc_sync2_reg <= `PCD_RST_BYTE;
        pd_sync1_reg <= `PCD_RST_BYTE;
        pd_sync2_reg <= `PCD_RST_BYTE;
    end
    else
    begin
        pc_sync1_reg <= portc_pad_in;
        pc_sync2_reg <= pc_sync1_reg;
        pd_sync1_reg <= portd_pad_in;
        pd_sync2_reg <= pd_sync1_reg;
    end
end

// spike filters sit between the pads and the two-wire logic
pcd_spike_filter #(
    .STABLE_CYCLES(SPIKE_CYCLES),
    .CNT_W(4)
) u_sda_filter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .level_in(pc_sync2_reg[`PCD_PC_SDA]),
    .level_out(sda_filt)
);

pcd_spike_filter #(
    .STABLE_CYCLES(SPIKE_CYCLES),
    .CNT_W(4)
) u_scl_filter (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .level_in(pc_sync2_reg[`PCD_PC_SCL]),
    .level_out(scl_filt)
);

// pad controls registered so every output comes from a flop
always @(posedge clk_in)
begin
    if (reset_in)
    begin
        portc_pad_out <= `PCD_RST_BYTE;
        portc_pad_oe_out <= `PCD_RST_BYTE;
        portc_pullup_out <= `PCD_RST_BYTE;
        portc_input_en_out <= `PCD_RST_BYTE;
        portd_pad_out <= `PCD_RST_BYTE;
        portd_pad_oe_out <= `PCD_RST_BYTE;
        portd_pullup_out <= `PCD_RST_BYTE;
        portd_input_en_out <= `PCD_RST_BYTE;
    end
    else
    begin
        portc_pad_out <= pc_val_next;
        portc_pad_oe_out <= pc_dir_next;
        portc_pullup_out <= pc_pullup_next;
        portc_input_en_out <= pc_die_next;
        portd_pad_out <= pd_val_next;
        portd_pad_oe_out <= pd_dir_next;
        portd_pullup_out <= pd_pullup_next;
        portd_input_en_out <= pd_die_next;
    end
end

// inputs back to the port readback and the functions; a disabled
// digital input reads zero except at the test logic inputs, so a floating pad cannot toggle other logic
always @(posedge clk_in)
begin
    if (reset_in)
    begin
        portc_pin_value_out <= `PCD_RST_BYTE;
        portd_pin_value_out <= `PCD_RST_BYTE;
        test_data_in_out <= 1'b0;
        test_mode_select_out <= 1'b0;
        test_clock_out <= 1'b0;
        two_wire_sda_out <= 1'b1;
        two_wire_scl_out <= 1'b1;
        timer1_capture_out <= 1'b0;
        ext_irq_zero_out <= 1'b0;
        ext_irq_one_out <= 1'b0;
        serial_rx_data_out <= 1'b1;
    end
    else
    begin
        portc_pin_value_out <= pc_sync2_reg & pc_die_next;
        portd_pin_value_out <= pd_sync2_reg & pd_die_next;
        // test pins reach the test logic straight from the synchroniser, not gated by the input enable
        test_data_in_out <= test_iface_enable_in &
            pc_sync2_reg[`PCD_PC_TDI];
        test_mode_select_out <= test_iface_enable_in &
            pc_sync2_reg[`PCD_PC_TMS];
        // sampled level only: the test logic clocks from this copy
        test_clock_out <= test_iface_enable_in &
            pc_sync2_reg[`PCD_PC_TCK];
        two_wire_sda_out <= sda_filt;
        two_wire_scl_out <= scl_filt;
        timer1_capture_out <= pd_sync2_reg[`PCD_PD_CAPT] &
            pd_die_next[`PCD_PD_CAPT];
        ext_irq_zero_out <= pd_sync2_reg[`PCD_PD_IRQ0] &
            pd_die_next[`PCD_PD_IRQ0];
        ext_irq_one_out <= pd_sync2_reg[`PCD_PD_IRQ1] &
            pd_die_next[`PCD_PD_IRQ1];
        // receiver idles high when disabled
        serial_rx_data_out <= serial_rx_enable_in ?
            pd_sync2_reg[`PCD_PD_RXD] : 1'b1;
    end
end

endmodule // pcd_pin_override

// ---- verification/pcd_pin_override_properties.sv ----
/*
 * pcd_pin_override_properties: timing checks on the override outputs.
 * assumes it is bound to pcd_pin_override and sees only its ports.
 */
`timescale 1ns/1ps
module pcd_pin_override_properties (
    input wire clk_in,
    input wire reset_in,
    input wire global_pullup_disable_in,
    input wire [7:0] portc_pad_in,
    input wire [7:0] portd_pad_in,
    input wire test_iface_enable_in,
    input wire instr_shift_state_in,
    input wire data_shift_state_in,
    input wire test_shift_data_in,
    input wire two_wire_enable_in,
    input wire two_wire_sda_drive_in,
    input wire two_wire_scl_drive_in,
    input wire timer2_compare_enable_in,
    input wire timer2_compare_in,
    input wire serial_tx_enable_in,
    input wire serial_tx_data_in,
    input wire serial_rx_enable_in,
    input wire [7:0] portc_pad_out,
    input wire [7:0] portc_pad_oe_out,
    input wire [7:0] portc_pullup_out,
    input wire [7:0] portc_input_en_out,
    input wire [7:0] portd_pad_out,
    input wire [7:0] portd_pad_oe_out,
    input wire [7:0] portd_pullup_out,
    input wire two_wire_sda_out,
    input wire timer1_capture_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    // test port in a shift state
    sequence tap_shifting;
        test_iface_enable_in && (instr_shift_state_in || data_shift_state_in);
    endsequence

    // data line held low long enough to clear sync and spike filter
    sequence sda_low_held;
        (two_wire_enable_in && !portc_pad_in[1]) [*6];
    endsequence

    tdo_float_a: assert property (
        test_iface_enable_in && !instr_shift_state_in && !data_shift_state_in
        |=> !portc_pad_oe_out[4]) else $error("tdo driven when idle");
    tdo_drive_a: assert property (
        tap_shifting |=> portc_pad_oe_out[4]
        && portc_pad_out[4] == $past(test_shift_data_in))
        else $error("tdo not driven with shift data");
    test_pins_a: assert property (
        test_iface_enable_in |=> (portc_pad_oe_out & 8'h2c) == 8'h00
        && (portc_input_en_out & 8'h3c) == 8'h00)
        else $error("test pins not taken over");
    test_pullup_a: assert property (
        test_iface_enable_in && !global_pullup_disable_in
        |=> (portc_pullup_out & 8'h3c) == 8'h2c)
        else $error("test pin pull-ups wrong");
    two_wire_pins_a: assert property (
        two_wire_enable_in |=> portc_pad_out[1:0] == 2'h0
        && portc_pad_oe_out[1] == $past(two_wire_sda_drive_in)
        && portc_pad_oe_out[0] == $past(two_wire_scl_drive_in))
        else $error("two-wire pins not open drain");
    pullup_off_a: assert property (
        global_pullup_disable_in |=> portc_pullup_out == 8'h00
        && portd_pullup_out == 8'h00) else $error("pull-up left on");
    tx_force_a: assert property (
        serial_tx_enable_in |=> portd_pad_oe_out[1] && !portd_pullup_out[1]
        && portd_pad_out[1] == $past(serial_tx_data_in))
        else $error("transmit pin not forced");
    rx_input_a: assert property (
        serial_rx_enable_in |=> !portd_pad_oe_out[0])
        else $error("receive pin driven");
    timer2_out_a: assert property (
        timer2_compare_enable_in
        |=> portd_pad_out[7] == $past(timer2_compare_in))
        else $error("timer 2 compare not on pin");
    sda_settle_a: assert property (
        sda_low_held |=> !two_wire_sda_out)
        else $error("data line input not settled");
    capture_path_a: assert property (
        portd_pad_in[6] [*5] |=> timer1_capture_out)
        else $error("capture input not passed");
endmodule // pcd_pin_override_properties

// ---- verification/pcd_pad_model.sv ----
/*
 * pcd_pad_model: eight pads with outside drivers and pull-ups.
 * assumes the bench chooses which pads an outside driver holds.
 */
`timescale 1ns/1ps
module pcd_pad_model (
    input wire clk_in,
    input wire [7:0] pad_out_in,
    input wire [7:0] oe_in,
    input wire [7:0] pullup_in,
    input wire [7:0] ext_en_in,
    input wire [7:0] ext_lvl_in,
    output wire [7:0] pad_lvl_out
);
    logic flip_reg = 1'b0;

    // an undriven pad with its pull-up off changes every cycle so no stale level reads right
    always @(posedge clk_in)
        flip_reg <= ~flip_reg;

    // chip drive wins; open-drain lines pull low via oe with value zero
    // test clock is an outside level sampled like any pad
    assign pad_lvl_out = (oe_in & pad_out_in)
        | (~oe_in & ext_en_in & ext_lvl_in)
        | (~oe_in & ~ext_en_in & (pullup_in | {8{flip_reg}}));
endmodule // pcd_pad_model

// ---- verification/pcd_pin_override_test.sv ----
/*
 * pcd_pin_override_test: directed checks of the pin override block.
 * assumes a 10 MHz clock and the pad model on both ports.
 */
`timescale 1ns/1ps
module pcd_pin_override_test;
    logic clk_in = 1'b0, reset_in = 1'b1, global_pullup_disable_in = 1'b0;
    logic test_iface_enable_in = 1'b0, instr_shift_state_in = 1'b0;
    logic data_shift_state_in = 1'b0, test_shift_data_in = 1'b0;
    logic two_wire_enable_in = 1'b0, two_wire_sda_drive_in = 1'b0;
    logic two_wire_scl_drive_in = 1'b0, timer2_compare_enable_in = 1'b0;
    logic timer2_compare_in = 1'b1, timer1_compare_a_enable_in = 1'b0;
    logic timer1_compare_a_in = 1'b1, timer1_compare_b_enable_in = 1'b0;
    logic timer1_compare_b_in = 1'b1, ext_irq_zero_enable_in = 1'b0;
    logic ext_irq_one_enable_in = 1'b0, serial_tx_enable_in = 1'b0;
    logic serial_tx_data_in = 1'b0, serial_rx_enable_in = 1'b0;
    logic [7:0] portc_value_in = 8'h00, portc_direction_in = 8'h00;
    logic [7:0] portd_value_in = 8'h00, portd_direction_in = 8'h00;
    logic [7:0] c_ext_en = 8'h00, c_ext = 8'h00;
    logic [7:0] d_ext_en = 8'h00, d_ext = 8'h00;
    wire [7:0] portc_pad_in, portd_pad_in, portc_pad_out, portc_pad_oe_out;
    wire [7:0] portc_pullup_out, portc_input_en_out, portd_pad_out;
    wire [7:0] portd_pad_oe_out, portd_pullup_out, portd_input_en_out;
    wire [7:0] portc_pin_value_out, portd_pin_value_out;
    wire test_data_in_out, test_mode_select_out, test_clock_out;
    wire two_wire_sda_out, two_wire_scl_out, timer1_capture_out;
    wire ext_irq_zero_out, ext_irq_one_out, serial_rx_data_out;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    // 100 ns clock
    always #50 clk_in = ~clk_in;

    pcd_pin_override u_pcd_pin_override (.*);
    pcd_pad_model u_pcd_pad_model_c (.clk_in(clk_in),
        .pad_out_in(portc_pad_out), .oe_in(portc_pad_oe_out),
        .pullup_in(portc_pullup_out), .ext_en_in(c_ext_en),
        .ext_lvl_in(c_ext), .pad_lvl_out(portc_pad_in));
    pcd_pad_model u_pcd_pad_model_d (.clk_in(clk_in),
        .pad_out_in(portd_pad_out), .oe_in(portd_pad_oe_out),
        .pullup_in(portd_pullup_out), .ext_en_in(d_ext_en),
        .ext_lvl_in(d_ext), .pad_lvl_out(portd_pad_in));

    task automatic stop_test;
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic cmp1(input logic got, input logic want);
        cmp8({7'h00, got}, {7'h00, want});
    endtask

    // inputs change 1 ns after the edge, outputs are settled by then
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // hang guard, the whole run needs about 60 cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        tick(3);
        cmp8(portc_pad_oe_out, 8'h00);
        cmp1(two_wire_sda_out, 1'b1);
        cmp1(serial_rx_data_out, 1'b1);
        reset_in = 1'b0;
        // plain port behaviour, then the global pull-up kill
        portc_value_in = 8'hc3;
        portc_direction_in = 8'h0f;
        portd_value_in = 8'h5a;
        portd_direction_in = 8'h33;
        tick(1);
        cmp8(portc_pad_out, 8'hc3);
        cmp8(portc_pad_oe_out, 8'h0f);
        cmp8(portc_pullup_out, 8'hc0);
        cmp8(portd_pullup_out, 8'h48);
        cmp8(portc_input_en_out, 8'hff);
        cmp8(portd_input_en_out, 8'hff);
        global_pullup_disable_in = 1'b1;
        tick(1);
        cmp8(portc_pullup_out | portd_pullup_out, 8'h00);
        global_pullup_disable_in = 1'b0;
        // test port: every shift state and data value
        test_iface_enable_in = 1'b1;
        c_ext_en = 8'h2c;
        c_ext = 8'h24;
        for (int i = 0; i < 8; i++)
        begin
            {instr_shift_state_in, data_shift_state_in} = i[2:1];
            test_shift_data_in = i[0];
            tick(1);
            cmp8(portc_pad_oe_out, {3'h0, i[2] | i[1], 4'h3});
            cmp8(portc_pad_out, {3'h6, i[0], 4'h3});
        end
        tick(3);
        cmp8(portc_pullup_out, 8'hec);
        cmp8(portc_input_en_out, 8'hc3);
        cmp8(portc_pin_value_out & 8'h3f, 8'h03);
        cmp1(test_data_in_out, 1'b1);
        cmp1(test_mode_select_out, 1'b0);
        cmp1(test_clock_out, 1'b1);
        // the global kill must reach the forced test pull-ups too
        global_pullup_disable_in = 1'b1;
        tick(1);
        cmp8(portc_pullup_out, 8'h00);
        global_pullup_disable_in = 1'b0;
        // two-wire lines, open drain with pull-ups from the port bits
        test_iface_enable_in = 1'b0;
        two_wire_enable_in = 1'b1;
        c_ext_en = 8'h00;
        portc_value_in = 8'h03;
        portc_direction_in = 8'h00;
        for (int i = 0; i < 4; i++)
        begin
            {two_wire_sda_drive_in, two_wire_scl_drive_in} = i[1:0];
            tick(6);
            cmp8(portc_pad_oe_out, {6'h00, i[1:0]});
            cmp8(portc_pad_out, 8'h00);
            cmp8(portc_pullup_out, 8'h03);
            cmp1(two_wire_sda_out, ~i[1]);
            cmp1(two_wire_scl_out, ~i[0]);
        end
        cmp1(test_clock_out, 1'b0);
        // compare outputs in every enable combination
        two_wire_enable_in = 1'b0;
        portd_value_in = 8'h00;
        portd_direction_in = 8'hb0;
        for (int i = 0; i < 8; i++)
        begin
            timer2_compare_enable_in = i[2];
            timer1_compare_a_enable_in = i[1];
            timer1_compare_b_enable_in = i[0];
            tick(1);
            cmp8(portd_pad_out, {i[2], 1'h0, i[1], i[0], 4'h0});
            cmp8(portd_pad_oe_out, 8'hb0);
        end
        // enabled compares must show their own level, not the port bits
        {timer2_compare_in, timer1_compare_a_in, timer1_compare_b_in} = 3'h0;
        portd_value_in = 8'hb0;
        tick(1);
        cmp8(portd_pad_out, 8'h00);
        // serial pins, interrupts and capture with outside levels
        {timer2_compare_enable_in, timer1_compare_a_enable_in} = 2'h0;
        timer1_compare_b_enable_in = 1'b0;
        portd_value_in = 8'h01;
        portd_direction_in = 8'h01;
        {serial_tx_enable_in, serial_tx_data_in, serial_rx_enable_in} = 3'h7;
        {ext_irq_zero_enable_in, ext_irq_one_enable_in} = 2'h3;
        d_ext_en = 8'h4d;
        for (int j = 0; j < 2; j++)
        begin
            d_ext = (j == 0) ? 8'h44 : 8'h09;
            tick(5);
            cmp8(portd_pad_oe_out, 8'h02);
            cmp8(portd_pad_out, 8'h03);
            cmp8(portd_pullup_out, 8'h01);
            cmp1(serial_rx_data_out, d_ext[0]);
            cmp1(ext_irq_zero_out, d_ext[2]);
            cmp1(ext_irq_one_out, d_ext[3]);
            cmp1(timer1_capture_out, d_ext[6]);
            cmp8(portd_pin_value_out & 8'h4d, d_ext & 8'h4d);
        end
        stop_test();
    end
endmodule // pcd_pin_override_test

bind pcd_pin_override pcd_pin_override_properties
    u_pcd_pin_override_properties (.*);
